// ---- hw/tsens_pkg.sv ----
// Constants, field layouts and types for the temperature sensor register block.
// Assumes a 50 MHz core clock; all users import the whole package.
package tsens_pkg;
    localparam int CORE_CLK_KHZ = 50_000;
    // Typical conversion times per resolution code, in ms
    localparam int CONV_MS_9    = 30;
    localparam int CONV_MS_10   = 60;
    localparam int CONV_MS_11   = 120;
    localparam int CONV_MS_12   = 240;

    localparam int WORD_BITS    = 16;
    localparam int TEMP_BITS    = 13;
    localparam logic [3:0] Z_FIRST_SHIFT = 4'hE;

    localparam logic [2:0]  CFG_TAIL    = 3'h2;
    localparam logic [2:0]  HIGH_TAIL   = 3'h6;
    localparam logic [2:0]  LOW_TAIL    = 3'h4;
    localparam logic [2:0]  TEMP_TAIL   = 3'h4;
    localparam logic [2:0]  READ_TAIL   = 3'h0;
    localparam logic [7:0]  SD_PATTERN  = 8'hFF;
    localparam logic [3:0]  CFG_TOP     = 4'h0;

    localparam logic [1:0]  RES_RESET   = 2'h3;
    localparam logic [12:0] HIGH_RESET  = 13'h0500;
    localparam logic [12:0] LOW_RESET   = 13'h04B0;
    localparam logic [12:0] TEMP_RESET  = 13'h0000;

    localparam logic [1:0]  PTR_TEMP    = 2'h0;
    localparam logic [1:0]  PTR_CFG     = 2'h1;
    localparam logic [1:0]  PTR_LOW     = 2'h2;
    localparam logic [1:0]  PTR_HIGH    = 2'h3;

    localparam logic [1:0]  TM_CMP      = 2'h0;
    localparam logic [1:0]  TM_INT      = 2'h1;
    localparam logic [1:0]  TM_ICMP     = 2'h2;

    // Consecutive faults needed, indexed by fault queue code
    localparam logic [3:0][2:0]  FQ_NEED  = {3'h6, 3'h4, 3'h2, 3'h1};
    // Kept temperature bits, indexed by resolution code
    localparam logic [3:0][12:0] RES_MASK = {13'h1FFF, 13'h1FFE, 13'h1FFC, 13'h1FF8};

    typedef struct packed {
        logic [1:0] conversion_delay_field;
        logic [1:0] resolution_field;
        logic [1:0] fault_queue_field;
        logic       alert_polarity_bit;
        logic [1:0] thermostat_mode_field;
    } cfg_s;

    localparam cfg_s CFG_RESET = '{conversion_delay_field: 2'h0, resolution_field: RES_RESET,
                                   fault_queue_field: 2'h0, alert_polarity_bit: 1'b0,
                                   thermostat_mode_field: TM_CMP};

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic sdio;
    } spi_pins_s;

    typedef enum logic [1:0] {
        PH_OUT = 2'b01,
        PH_IN  = 2'b10
    } phase_e;
endpackage

// ---- hw/pin_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are plain levels; only the second stage may be read.
`timescale 1ns/10ps
module pin_sync #(
    parameter int         W         = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // pin_sync

// ---- hw/fault_counter.sv ----
// Counter of consecutive faulting conversions with a programmable need.
// Assumes sample is a one-cycle pulse once per completed conversion.
`timescale 1ns/10ps
module fault_counter
    import tsens_pkg::*;
#(
    parameter int W = 3
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         sample,
    input  wire logic         fault,
    input  wire logic [W-1:0] need,
    output logic              met
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    // saturate at need, a good sample breaks the run
    assign cnt_nxt = !fault ? '0 : (cnt_r >= need) ? cnt_r : cnt_r + W'(1);
    assign met     = (cnt_r >= need);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else if (sample)
            cnt_r <= cnt_nxt;
    end

    run_break_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sample && !fault |=> cnt_r == '0 && !met)
        else $error("fault run not broken by a good sample");
endmodule // fault_counter

// ---- hw/temp_sensor_regs_alert.sv ----
// Register set, conversion pacing, serial framing and alert logic of the sensor.
// Assumes sensor_code is a settled converter value on core_clk; serial pins are asynchronous.
`timescale 1ns/10ps

// Contract
// - Result register holds latest completed conversion; host cannot write it.
// - Result shifts out 13 temperature bits, D2 as one, D1 and D0 undriven.
// - Result reads zero degrees after reset until first conversion completes.
// - Temperature is 13-bit two's complement, 0.0625 degree steps, bits 15..3.
// - Lower resolutions force unused low temperature bits to zero.
// - Configuration is 16-bit read/write, transferred most significant bit first.
// - Reset sets both resolution bits, clears every other configurable bit.
// - Configuration layout: zero top, delay, resolution, queue, polarity, mode, 010.
// - Write word with low byte all ones powers down after current conversion.
// - Any later word with low byte not all ones resumes conversions.
// - Mode field picks comparator, interrupt, interrupt-comparator; comparator default.
// - Polarity zero gives active low alert; one inverts it.
// - Fault queue needs 1, 2, 4 or 6 consecutive faults.
// - Comparator: assert on high faults, deassert on same count of low faults.
// - Interrupt: assert on high faults, clear on any read or shutdown entry.
// - Interrupt arming alternates between high event and below-low event.
// - Interrupt-comparator deasserts after low faults and a following communication.
// - Limits reset to 80 and 75 degrees in temperature code.
// - Comparisons use all 13 bits of result and limits at any resolution.
// - Limit low bits read 110 for high and 100 for low.
// - Resolution codes give 9 to 12 bits with 30 to 240 ms conversions.
// - Read pointer selects source, returns to result after each full read.
module temp_sensor_regs_alert
    import tsens_pkg::*;
#(
    parameter int CONV_CYC_9  = CONV_MS_9 * CORE_CLK_KHZ,
    parameter int CONV_CYC_10 = CONV_MS_10 * CORE_CLK_KHZ,
    parameter int CONV_CYC_11 = CONV_MS_11 * CORE_CLK_KHZ,
    parameter int CONV_CYC_12 = CONV_MS_12 * CORE_CLK_KHZ
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        sdio_in,
    output logic             sdio_out,
    output logic             sdio_oe,
    output logic             alert_out,
    output logic             alert_oe,
    input  wire logic [12:0] sensor_code,
    output logic             conv_active
);
    spi_pins_s   pins;
    phase_e      phase_r;
    cfg_s        cfg_r;
    logic        cs_d_r, sck_d_r, src_temp_r, power_down_state_r, sd_pending_r, upd_r, ev_r, seen_conv_r;
    logic        selected, sck_rise, sck_fall, cs_fall, in_done, out_done, load, sd_enter, conv_done;
    logic        cmd_read, wr_sd, wr_cfg, wr_low, wr_high, wake, hi_met, lo_met;
    logic        alert_r, alert_nxt, armed_low_r, armed_low_nxt, lo_seen_r, lo_seen_nxt;
    logic [1:0]  ptr_r, ptr_nxt;
    logic [2:0]  fq_need;
    logic [3:0]  bit_cnt_r, sh_cnt_r;
    logic [12:0] result_r, low_r, high_r;
    logic [15:0] shift_r, rx_r, rx_word, temp_word, cfg_word, low_word, high_word, sel_word;
    logic [23:0] conv_cnt_r, conv_last;

    pin_sync #(.W(3), .RST_VAL(3'h4)) u_pin_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        ({cs_n, sck, sdio_in}),
        .q        (pins)
    );

    assign selected = !pins.cs_n;
    assign sck_rise = selected && pins.sck && !sck_d_r;
    assign sck_fall = selected && !pins.sck && sck_d_r;
    assign cs_fall  = !pins.cs_n && cs_d_r;
    assign rx_word  = {rx_r[14:0], pins.sdio};
    assign in_done  = sck_rise && phase_r == PH_IN && bit_cnt_r == 4'hF;
    assign out_done = sck_rise && phase_r == PH_OUT && bit_cnt_r == 4'hF;
    assign load     = cs_fall || in_done;

    // shutdown pattern is checked before any other decode
    assign wr_sd    = in_done && rx_word[7:0] == SD_PATTERN;
    // any other received word wakes the converter
    assign wake     = in_done && !wr_sd;
    // Read command and limit writes share bit 15, so the low three bits decide
    assign cmd_read = wake && rx_word[15] && rx_word[2:0] == READ_TAIL;
    assign wr_cfg   = wake && rx_word[2:0] == CFG_TAIL;
    assign wr_low   = wake && rx_word[2:0] == LOW_TAIL;
    assign wr_high  = wake && rx_word[2:0] == HIGH_TAIL;

    // read command loads pointer, a completed read returns it to the result
    assign ptr_nxt  = cmd_read ? rx_word[4:3] : out_done ? PTR_TEMP : ptr_r;

    // result code left-aligned in bits 15..3
    // result word carries D2 high; D1 and D0 are released, not driven
    assign temp_word = {result_r, TEMP_TAIL};
    // configuration fields sit between fixed top and tail
    assign cfg_word  = {CFG_TOP, cfg_r, CFG_TAIL};
    // fixed tails identify each limit register
    assign low_word  = {low_r, LOW_TAIL};
    assign high_word = {high_r, HIGH_TAIL};
    assign sel_word  = ptr_nxt == PTR_CFG ? cfg_word :
                       ptr_nxt == PTR_LOW ? low_word :
                       ptr_nxt == PTR_HIGH ? high_word : temp_word;

    // most significant bit first in both directions
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cs_d_r     <= 1'b1;
            sck_d_r    <= 1'b0;
            phase_r    <= PH_OUT;
            bit_cnt_r  <= 4'h0;
            sh_cnt_r   <= 4'h0;
            shift_r    <= 16'h0000;
            rx_r       <= 16'h0000;
            ptr_r      <= PTR_TEMP;
            src_temp_r <= 1'b1;
        end
        else
        begin
            cs_d_r  <= pins.cs_n;
            sck_d_r <= pins.sck;
            ptr_r   <= ptr_nxt;
            if (pins.cs_n)
            begin
                phase_r   <= PH_OUT;
                bit_cnt_r <= 4'h0;
            end
            else if (sck_rise)
            begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                if (bit_cnt_r == 4'hF)
                    phase_r <= (phase_r == PH_OUT) ? PH_IN : PH_OUT;
                if (phase_r == PH_IN)
                    rx_r <= rx_word;
            end
            if (load)
            begin
                shift_r    <= sel_word;
                sh_cnt_r   <= 4'h0;
                src_temp_r <= ptr_nxt == PTR_TEMP;
            end
            else if (sck_fall && phase_r == PH_OUT && bit_cnt_r != 4'h0)
            begin
                shift_r  <= {shift_r[14:0], 1'b0};
                sh_cnt_r <= sh_cnt_r + 4'h1;
            end
        end
    end

    assign sdio_out = shift_r[15];
    // pin released for the two lowest result bits
    assign sdio_oe  = selected && phase_r == PH_OUT && !(src_temp_r && sh_cnt_r >= Z_FIRST_SHIFT);

    // conversion length follows the resolution code
    assign conv_last = cfg_r.resolution_field == 2'h0 ? 24'(CONV_CYC_9 - 1) :
                       cfg_r.resolution_field == 2'h1 ? 24'(CONV_CYC_10 - 1) :
                       cfg_r.resolution_field == 2'h2 ? 24'(CONV_CYC_11 - 1) : 24'(CONV_CYC_12 - 1);
    assign conv_done   = !power_down_state_r && conv_cnt_r >= conv_last;
    assign conv_active = !power_down_state_r;
    // power down lands only at the end of the running conversion
    assign sd_enter    = sd_pending_r && conv_done;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cfg_r              <= CFG_RESET;
            // limits start at 80 and 75 degrees
            low_r              <= LOW_RESET;
            high_r             <= HIGH_RESET;
            // result reads zero until a conversion ends
            result_r           <= TEMP_RESET;
            power_down_state_r <= 1'b0;
            sd_pending_r       <= 1'b0;
            conv_cnt_r         <= 24'h00_0000;
            upd_r              <= 1'b0;
            ev_r               <= 1'b0;
            seen_conv_r        <= 1'b0;
        end
        else
        begin
            // reset above holds resolution at 12 bits and all else zero
            if (wr_cfg)
                cfg_r <= rx_word[11:3];
            if (wr_low)
                low_r <= rx_word[15:3];
            if (wr_high)
                high_r <= rx_word[15:3];
            conv_cnt_r <= (conv_done || power_down_state_r) ? 24'h00_0000 : conv_cnt_r + 24'h00_0001;
            // only a finished conversion writes the result
            // low bits beyond the resolution are forced to zero
            if (conv_done)
                result_r <= sensor_code & RES_MASK[cfg_r.resolution_field];
            if (wake)
            begin
                sd_pending_r       <= 1'b0;
                power_down_state_r <= 1'b0;
            end
            else if (sd_enter)
            begin
                sd_pending_r       <= 1'b0;
                power_down_state_r <= 1'b1;
            end
            else if (wr_sd)
                sd_pending_r <= 1'b1;
            upd_r       <= conv_done;
            ev_r        <= upd_r;
            seen_conv_r <= seen_conv_r || conv_done;
        end
    end

    assign fq_need = FQ_NEED[cfg_r.fault_queue_field];

    // all 13 bits compared, signed, once per conversion
    // counters step on the cycle after the result updates
    fault_counter #(.W(3)) u_high_faults (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .sample   (upd_r),
        .fault    ($signed(result_r) >= $signed(high_r)),
        .need     (fq_need),
        .met      (hi_met)
    );

    fault_counter #(.W(3)) u_low_faults (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .sample   (upd_r),
        .fault    ($signed(result_r) < $signed(low_r)),
        .need     (fq_need),
        .met      (lo_met)
    );

    // mode field selects the alert behaviour; reserved acts as comparator
    always_comb
    begin
        alert_nxt     = alert_r;
        armed_low_nxt = armed_low_r;
        lo_seen_nxt   = lo_seen_r;
        case (cfg_r.thermostat_mode_field)
            TM_INT:
            begin
                // set wins over a clear in the same cycle
                // each clear flips the armed event
                if (!alert_r && ev_r && (armed_low_r ? lo_met : hi_met))
                    alert_nxt = 1'b1;
                else if (alert_r && (out_done || sd_enter))
                begin
                    alert_nxt     = 1'b0;
                    armed_low_nxt = !armed_low_r;
                end
            end
            TM_ICMP:
            begin
                // low faults must be followed by a bus communication
                if (!alert_r && ev_r && hi_met)
                begin
                    alert_nxt   = 1'b1;
                    lo_seen_nxt = 1'b0;
                end
                else if (alert_r && lo_seen_r && cs_fall)
                begin
                    alert_nxt   = 1'b0;
                    lo_seen_nxt = 1'b0;
                end
                else if (alert_r && ev_r && lo_met)
                    lo_seen_nxt = 1'b1;
            end
            default:
            begin
                if (!alert_r && ev_r && hi_met)
                    alert_nxt = 1'b1;
                else if (alert_r && ev_r && lo_met)
                    alert_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            alert_r     <= 1'b0;
            armed_low_r <= 1'b0;
            lo_seen_r   <= 1'b0;
        end
        else
        begin
            alert_r     <= alert_nxt;
            armed_low_r <= armed_low_nxt;
            lo_seen_r   <= lo_seen_nxt;
        end
    end

    // open drain pulls low when the pin level must be low
    assign alert_out = 1'b0;
    assign alert_oe  = alert_r ^ cfg_r.alert_polarity_bit;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_pd_entry;
        sd_pending_r && !wake ##0 conv_done;
    endsequence

    result_hold_a: assert property (!conv_done |=> $stable(result_r))
        else $error("result changed without a conversion");
    temp_release_a: assert property (phase_r == PH_OUT && src_temp_r && sh_cnt_r >= 4'hE |-> !sdio_oe)
        else $error("low result bits were driven");
    zero_start_a: assert property (!seen_conv_r |-> result_r == TEMP_RESET)
        else $error("result not zero before first conversion");
    res_mask_a: assert property (conv_done && cfg_r.resolution_field == 2'h0 |=> result_r[2:0] == 3'h0)
        else $error("unused bits kept at 9-bit resolution");
    pd_entry_a: assert property (s_pd_entry |=> power_down_state_r && !conv_active)
        else $error("power down missed conversion end");
    pd_only_end_a: assert property ($rose(power_down_state_r) |-> $past(conv_done))
        else $error("power down before conversion end");
    wake_up_a: assert property (wake |=> !power_down_state_r)
        else $error("converter not resumed");
    pol_pin_a: assert property (alert_oe == (alert_r != cfg_r.alert_polarity_bit))
        else $error("alert pin level wrong for polarity");
    cmp_set_a: assert property (cfg_r.thermostat_mode_field == TM_CMP && !alert_r && ev_r && hi_met |=> alert_r)
        else $error("comparator alert not raised");
    int_clear_a: assert property (cfg_r.thermostat_mode_field == TM_INT && alert_r && out_done
                                  |=> !alert_r && armed_low_r != $past(armed_low_r))
        else $error("interrupt alert not cleared by read");
    ptr_return_a: assert property (out_done && !cmd_read |=> ptr_r == PTR_TEMP)
        else $error("pointer not returned after read");
endmodule // temp_sensor_regs_alert

// ---- dv/tsens_host.sv ----
// Serial host model: frames, word reads and word writes on the shared data pin.
// Assumes sck idles low; the device shifts on falls and samples on rises.
`timescale 1ns/10ps
module tsens_host (
    input  wire logic core_clk,
    output logic      cs_n,
    output logic      sck,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe
);
    logic drv = 1'b0;
    logic bit_v = 1'b0;
    logic fill_r = 1'b0;
    initial cs_n = 1'b1;
    initial sck = 1'b0;
    // Released pin toggles, so a stale level never passes for data
    assign sdio_in = sdio_oe ? sdio_out : (drv ? bit_v : fill_r);
    always @(posedge core_clk) fill_r <= ~fill_r;
    task automatic open_frame();
        cs_n = 1'b0;
        #100;
    endtask
    task automatic close_frame();
        #100;
        cs_n = 1'b1;
        #300;
    endtask
    task automatic rd(output logic [15:0] d, output logic [15:0] oe);
        for (int i = 15; i >= 0; i--)
        begin
            #100;
            d[i] = sdio_in;
            oe[i] = sdio_oe;
            sck = 1'b1;
            #60;
            sck = 1'b0;
        end
    endtask
    // commands only after a full read
    task automatic wr(input logic [15:0] w);
        drv = 1'b1;
        for (int i = 15; i >= 0; i--)
        begin
            bit_v = w[i];
            #100;
            sck = 1'b1;
            #60;
            sck = 1'b0;
        end
        drv = 1'b0;
    endtask
endmodule // tsens_host

// ---- dv/tb_temp_sensor_regs_alert.sv ----
// Bench for the sensor register block: register access, results, alert modes, power-down.
// Assumes a pull-up on the alert pin and conversions shortened to 40..100 cycles.
`timescale 1ns/10ps
module tb_temp_sensor_regs_alert;
    localparam logic [12:0] HOT  = 13'h0108;
    localparam logic [12:0] COLD = 13'h1F00;
    logic        core_clk, rst_n, cs_n, sck, sdio_in, sdio_out, sdio_oe;
    logic        alert_out, alert_oe, conv_active;
    logic [12:0] sensor_code;
    logic [15:0] d, oe_w;
    int          n_fail, checked, n;
    wire logic   alert_pin;
    // Open-drain alert with a pull-up
    assign alert_pin = alert_oe ? alert_out : 1'b1;
    temp_sensor_regs_alert #(
        .CONV_CYC_9  (40),
        .CONV_CYC_10 (60),
        .CONV_CYC_11 (80),
        .CONV_CYC_12 (100)
    ) i_dut (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .cs_n        (cs_n),
        .sck         (sck),
        .sdio_in     (sdio_in),
        .sdio_out    (sdio_out),
        .sdio_oe     (sdio_oe),
        .alert_out   (alert_out),
        .alert_oe    (alert_oe),
        .sensor_code (sensor_code),
        .conv_active (conv_active)
    );
    tsens_host i_host (
        .core_clk (core_clk),
        .cs_n     (cs_n),
        .sck      (sck),
        .sdio_in  (sdio_in),
        .sdio_out (sdio_out),
        .sdio_oe  (sdio_oe)
    );
    always #10 core_clk = ~core_clk;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic set_code(input logic [12:0] c);
        @(posedge core_clk);
        #2 sensor_code = c;
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #2;
    endtask
    task automatic hold(input int c, input logic e);
        tick(c);
        chk("alert pin", {15'h0, e}, {15'h0, alert_pin});
    endtask
    task automatic xfer(input logic [15:0] w);
        i_host.wr(w);
        i_host.rd(d, oe_w);
    endtask
    task automatic put(input logic [15:0] w);
        i_host.open_frame();
        i_host.rd(d, oe_w);
        i_host.wr(w);
        i_host.close_frame();
    endtask
    task automatic get(input logic [1:0] p);
        i_host.open_frame();
        i_host.rd(d, oe_w);
        xfer({1'b1, 10'h0, p, 3'h0});
        i_host.close_frame();
    endtask
    initial
    begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        sensor_code = 13'h0190;
        n_fail = 0;
        checked = 0;
        tick(6);
        rst_n = 1'b1;
        tick(3);
        i_host.open_frame();
        i_host.rd(d, oe_w);
        chk("reset result", 16'h0004, d & 16'hFFFC);
        chk("result drive", 16'hFFFC, oe_w);
        xfer(16'h8008);
        chk("reset config", 16'h0302, d);
        xfer(16'h8018);
        chk("reset high", 16'h2806, d);
        xfer(16'h8010);
        chk("reset low", 16'h2584, d);
        xfer(16'h0302);
        chk("result", 16'h0C84, d & 16'hFFFC);
        i_host.close_frame();
        set_code(13'h1FFF);
        for (int r = 0; r < 4; r++)
        begin
            put({4'h0, r[1:0], r[1:0], 8'h02});
            get(2'h1);
            chk("config", {4'h0, r[1:0], r[1:0], 8'h02}, d);
            get(2'h0);
            chk("result", {13'h1FFF << (3 - r), 3'h4}, d & 16'hFFFC);
        end
        put(16'h080E);
        put(16'h0784);
        get(2'h3);
        chk("high", 16'h080E, d);
        get(2'h2);
        chk("low", 16'h0784, d);
        for (int q = 0; q < 4; q++)
        begin
            n = (q == 0) ? 1 : 2 * q;
            put({8'h00, q[1:0], 1'b0, {2{q == 3}}, 3'h2});
            set_code(COLD);
            hold(300, 1'b1);
            set_code(HOT);
            hold(40 * n - 38, 1'b1);
            hold(43, 1'b0);
            set_code(COLD);
            hold(40 * n - 38, 1'b0);
            hold(43, 1'b1);
        end
        put(16'h0002);
        set_code(13'h0107);
        hold(100, 1'b1);
        put(16'h0022);
        hold(100, 1'b0);
        set_code(HOT);
        hold(100, 1'b1);
        put(16'h000A);
        set_code(COLD);
        get(2'h0);
        get(2'h0);
        hold(100, 1'b1);
        set_code(HOT);
        hold(100, 1'b0);
        get(2'h0);
        hold(100, 1'b1);
        set_code(COLD);
        hold(100, 1'b0);
        get(2'h3);
        hold(100, 1'b1);
        set_code(HOT);
        hold(100, 1'b0);
        put(16'h12FF);
        tick(100);
        chk("converting", 16'h0, {15'h0, conv_active});
        set_code(13'h0050);
        tick(100);
        i_host.open_frame();
        i_host.rd(d, oe_w);
        chk("held result", 16'h0844, d & 16'hFFFC);
        xfer(16'h2AA8);
        chk("held result", 16'h0844, d & 16'hFFFC);
        i_host.close_frame();
        tick(100);
        chk("converting", 16'h1, {15'h0, conv_active});
        get(2'h0);
        chk("result", 16'h0284, d & 16'hFFFC);
        put(16'h0012);
        set_code(HOT);
        hold(100, 1'b0);
        set_code(COLD);
        hold(100, 1'b0);
        put(16'h0012);
        hold(5, 1'b1);
        give_verdict();
    end
endmodule // tb_temp_sensor_regs_alert
